// ### bench/dfsb_bank_asserts.sv
// checker for the fault-status bank: select timing and pull-down control
// assumes it is bound to dfsb_bank with clk_en held high by the bench
`timescale 1ns/10ps
module dfsb_bank_asserts (
  input wire logic       sys_clk,
  input wire logic       rst_b,
  input wire logic       clk_en,
  input wire logic       spi_sclk,
  input wire logic       chip_select_low_active,
  input wire logic       spi_miso,
  input wire logic       spi_miso_oe,
  input wire logic       sleep_mode,
  input wire logic [8:0] pulldown_enable
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  sequence s_sel;
    (!chip_select_low_active)[*6];
  endsequence
  sequence s_idle;
    chip_select_low_active[*6];
  endsequence
  // no frame and no sleep: nothing may move the pull-downs
  sequence s_quiet;
    (!sleep_mode && chip_select_low_active)[*8];
  endsequence
  sequence s_hold;
    (!chip_select_low_active && !spi_sclk)[*8];
  endsequence
  a_pd_reset_on: assert property (
    $rose(rst_b) |-> pulldown_enable == 9'h1ff)
    else $error("pull-downs not on after reset");
  a_sleep_pd_off: assert property (
    clk_en && sleep_mode |=> pulldown_enable == 9'h000)
    else $error("pull-downs on in sleep");
  a_pd_stable: assert property (
    s_quiet |=> $stable(pulldown_enable))
    else $error("pull-downs changed without command");
  a_oe_rise_bound: assert property (
    $fell(chip_select_low_active) |-> ##[2:5] spi_miso_oe)
    else $error("response not started after select");
  a_oe_fall_bound: assert property (
    $rose(chip_select_low_active) |-> ##[2:5] !spi_miso_oe)
    else $error("response not ended after deselect");
  a_oe_on_frame: assert property (
    s_sel |-> spi_miso_oe)
    else $error("output idle inside frame");
  a_oe_off_idle: assert property (
    s_idle |-> !spi_miso_oe)
    else $error("output active outside frame");
  a_miso_hold: assert property (
    s_hold |=> $stable(spi_miso))
    else $error("response bit moved without clock");
endmodule

bind dfsb_bank dfsb_bank_asserts u_asrt (
  .sys_clk(sys_clk),
  .rst_b(rst_b),
  .clk_en(clk_en),
  .spi_sclk(spi_sclk),
  .chip_select_low_active(chip_select_low_active),
  .spi_miso(spi_miso),
  .spi_miso_oe(spi_miso_oe),
  .sleep_mode(sleep_mode),
  .pulldown_enable(pulldown_enable)
);

// ### bench/dfsb_spi_master.sv
// controller model: serial master, mode 0, 160 ns clock, msb first
// assumes the bench calls xfer and reads rx_word when rx_cnt moves
`timescale 1ns/10ps
module dfsb_spi_master (
  output logic        spi_sclk,
  output logic        chip_select_low_active,
  output logic        spi_mosi,
  input  wire logic   spi_miso,
  output logic [15:0] rx_word,
  output logic [7:0]  rx_cnt
);
  initial begin
    spi_sclk = 1'b0;
    chip_select_low_active = 1'b1;
    spi_mosi = 1'b1;
    rx_word = 16'h0000;
    rx_cnt = 8'h00;
  end
  // a count other than 16 makes a frame that must be refused
  task automatic xfer(input logic [15:0] tx, input int n);
    logic [15:0] rx;
    rx = 16'h0000;
    #7;
    chip_select_low_active = 1'b0;
    spi_mosi = tx[15];
    #200;
    for (int i = 0; i < n; i++) begin
      spi_sclk = 1'b1;
      #80;
      // miso moves some cycles after our fall, so take it before the next
      rx = {rx[14:0], spi_miso};
      spi_sclk = 1'b0;
      if (i < n - 1)
        spi_mosi = tx[14 - i];
      #80;
    end
    chip_select_low_active = 1'b1;
    spi_mosi = ~spi_mosi;
    rx_word = rx;
    rx_cnt = rx_cnt + 8'h01;
    #200;
  endtask
endmodule

// ### bench/driver_fault_status_bank_tb.sv
// self-checking bench for the fault-status bank over its serial port
// assumes a short open-load filter and the master model on the pins
`timescale 1ns/10ps
module driver_fault_status_bank_tb;
  logic        sys_clk;
  logic        rst_b;
  logic        sleep_mode;
  logic        spi_sclk;
  logic        chip_select_low_active;
  logic        spi_mosi;
  logic        spi_miso;
  logic        spi_miso_oe;
  logic [8:0]  drive_on;
  logic [8:0]  ol_compare;
  logic [8:0]  overcurrent_flag;
  logic [8:0]  overtemperature_flag;
  logic [8:0]  short_to_ground_flag;
  logic [8:0]  pulldown_enable;
  logic [15:0] rx_word;
  logic [7:0]  rx_cnt;
  logic [16:0] exp_q[$];
  logic [16:0] exp_e;
  logic [3:0]  last_a;
  logic [31:0] seed;
  logic [31:0] r;
  int          num_errors;
  int          total_checks;

  dfsb_bank #(.OL_FILTER_CYCLES(20)) u_dut (
    .sys_clk(sys_clk), .rst_b(rst_b), .clk_en(1'b1),
    .spi_sclk(spi_sclk), .chip_select_low_active(chip_select_low_active),
    .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
    .sleep_mode(sleep_mode), .drive_on(drive_on), .ol_compare(ol_compare),
    .overcurrent_flag(overcurrent_flag),
    .overtemperature_flag(overtemperature_flag),
    .short_to_ground_flag(short_to_ground_flag),
    .watchdog_state(8'h00), .sensor_faults(8'h00), .supply_status(8'h00),
    .pulldown_enable(pulldown_enable));

  dfsb_spi_master u_mst (
    .spi_sclk(spi_sclk), .chip_select_low_active(chip_select_low_active),
    .spi_mosi(spi_mosi), .spi_miso(spi_miso),
    .rx_word(rx_word), .rx_cnt(rx_cnt));

  always #10 sys_clk = ~sys_clk;

  function automatic logic [31:0] xorshift();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [8:0] fexp(input int c,
                                      input logic [8:0] ol, oc, ot, sg);
    logic [3:0] b;
    b = {ol[c], oc[c], ot[c], sg[c]} & dfsb_pkg::CH_FAULT_MASK[c];
    return {1'b0, |b, 3'h0, b};
  endfunction

  task automatic check(input string name, input logic [15:0] exp, seen);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_sim();
    if (num_errors == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // each frame is answered with the address of the last 16-bit frame before it
  task automatic xf(input logic [15:0] tx, input logic chk,
                    input logic [8:0] v, input int n);
    exp_q.push_back({chk, 3'h0, last_a, v});
    u_mst.xfer(tx, n);
    if (n == 16)
      last_a = tx[14:11];
  endtask

  // a frame that answers a channel clears it; if the last 16-bit frame was sent to this address, a frame to 0xe goes first and answers it instead
  task automatic rd(input logic [3:0] a, input logic [8:0] v);
    if (last_a == a)
      xf(16'h7000, 1'b0, 9'h000, 16);
    xf({1'b0, a, 11'h000}, 1'b0, 9'h000, 16);
    xf({1'b0, a, 11'h000}, 1'b1, v, 16);
  endtask

  task automatic pulse(input logic [8:0] ol, oc, ot, sg, input int gap);
    xf(16'h7000, 1'b0, 9'h000, 16);
    repeat (gap) @(negedge sys_clk);
    @(negedge sys_clk);
    ol_compare = ol;
    overcurrent_flag = oc;
    overtemperature_flag = ot;
    short_to_ground_flag = sg;
    repeat (4) @(negedge sys_clk);
    ol_compare = 9'h000;
    overcurrent_flag = 9'h000;
    overtemperature_flag = 9'h000;
    short_to_ground_flag = 9'h000;
    repeat (30) @(negedge sys_clk);
  endtask

  always @(rx_cnt) begin
    if (exp_q.size() > 0) begin
      exp_e = exp_q.pop_front();
      if (exp_e[16])
        check("spi_response", exp_e[15:0], rx_word);
    end
  end

  initial begin
    // about four times the frames the scenarios send, well under the cap
    #1000000;
    num_errors++;
    end_sim();
  end

  initial begin
    sys_clk = 1'b0;
    rst_b = 1'b0;
    sleep_mode = 1'b0;
    drive_on = 9'h000;
    ol_compare = 9'h000;
    overcurrent_flag = 9'h000;
    overtemperature_flag = 9'h000;
    short_to_ground_flag = 9'h000;
    last_a = 4'h0;
    seed = 32'h0000_0030;
    num_errors = 0;
    total_checks = 0;
    repeat (20) @(negedge sys_clk);
    rst_b = 1'b1;
    repeat (30) @(negedge sys_clk);
    rd(4'h6, 9'h1ff);
    for (int c = 0; c < 9; c++)
      rd(dfsb_pkg::CH_ADDR[c], 9'h000);
    for (int k = 0; k < 2; k++) begin
      r = xorshift();
      @(negedge sys_clk);
      drive_on = r[8:0];
      pulse(9'h1ff, r[17:9], r[26:18], r[31:23], 30);
      for (int c = 0; c < 9; c++)
        rd(dfsb_pkg::CH_ADDR[c],
           fexp(c, ~drive_on, r[17:9], r[26:18], r[31:23]));
    end
    @(negedge sys_clk);
    drive_on = 9'h000;
    pulse(9'h001, 9'h000, 9'h000, 9'h000, 0);
    rd(4'h0, 9'h000);
    pulse(9'h001, 9'h000, 9'h000, 9'h000, 30);
    rd(4'h0, 9'h088);
    rd(4'h0, 9'h000);
    xf({1'b1, 4'h6, 2'h0, 9'h1fe}, 1'b0, 9'h000, 16);
    pulse(9'h003, 9'h001, 9'h000, 9'h000, 30);
    rd(4'h0, 9'h084);
    rd(4'h1, 9'h088);
    xf({1'b1, 4'h6, 2'h0, 9'h1ff}, 1'b0, 9'h000, 15);
    rd(4'h6, 9'h1fe);
    @(negedge sys_clk);
    sleep_mode = 1'b1;
    repeat (2) @(negedge sys_clk);
    check("pulldown_enable", 16'h0000, {7'h00, pulldown_enable});
    sleep_mode = 1'b0;
    repeat (2) @(negedge sys_clk);
    check("pulldown_enable", 16'h01fe, {7'h00, pulldown_enable});
    end_sim();
  end
endmodule

// ### core/dfsb_bank.sv
// driver fault-status register bank with serial slave and open-load logic
// assumes the serial pins are asynchronous to sys_clk and that the fault,
// drive and status inputs come from logic on sys_clk
`timescale 1ns/10ps
module dfsb_bank #(
  parameter int unsigned OL_FILTER_CYCLES = dfsb_pkg::OL_FILTER_CYCLES,
  // arbitrary identification values
  parameter logic [2:0]  MODEL_CODE       = 3'h2,
  parameter logic [4:0]  REVISION         = 5'h01
) (
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  input  wire logic       clk_en,
  input  wire logic       spi_sclk,
  input  wire logic       chip_select_low_active,
  input  wire logic       spi_mosi,
  output logic            spi_miso,
  output logic            spi_miso_oe,
  input  wire logic       sleep_mode,
  input  wire logic [8:0] drive_on,
  input  wire logic [8:0] ol_compare,
  input  wire logic [8:0] overcurrent_flag,
  input  wire logic [8:0] overtemperature_flag,
  input  wire logic [8:0] short_to_ground_flag,
  input  wire logic [7:0] watchdog_state,
  input  wire logic [7:0] sensor_faults,
  input  wire logic [7:0] supply_status,
  output logic [8:0]      pulldown_enable
);
  localparam int unsigned N = dfsb_pkg::NUM_CH;
  localparam int unsigned DW = dfsb_pkg::DATA_W;

  // pin synchronisers; stage one feeds stage two only
  logic         sclk_s1;
  logic         sclk_s2;
  logic         sclk_d;
  logic         cs_s1;
  logic         cs_s2;
  logic         cs_d;
  logic         mosi_s1;
  logic         mosi_s2;
  logic [N-1:0] ol_s1;
  logic [N-1:0] ol_s2;

  logic         sclk_rise;
  logic         sclk_fall;
  logic         cs_fall;
  logic         cs_rise;

  dfsb_pkg::dfsb_spi_state_t spi_state;
  dfsb_pkg::dfsb_spi_state_t next_spi_state;

  logic [4:0]   bit_count;
  logic [15:0]  rx_shift;
  logic [15:0]  tx_shift;
  logic [3:0]   resp_addr;
  logic         frame_ok;
  logic         frame_bad;
  logic [3:0]   rx_addr;
  logic         rx_write;
  logic [8:0]   pulldown_cmd;
  logic         spi_frame_error;

  logic [N-1:0] ol_latch;
  logic [N-1:0] oc_latch;
  logic [N-1:0] ot_latch;
  logic [N-1:0] sg_latch;
  logic [N-1:0] ch_clear;
  logic [N-1:0] ch_summary;
  logic [7:0]   fault_reg [N];

  logic [7:0]   onoff_reg;
  logic [7:0]   supply_reg;
  logic         any_fault;
  logic [DW-1:0] read_value;

  dfsb_ol_if #(.N(N)) ol_link ();

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_s1 <= 1'b0;
      sclk_s2 <= 1'b0;
      sclk_d  <= 1'b0;
      cs_s1   <= 1'b1;
      cs_s2   <= 1'b1;
      cs_d    <= 1'b1;
      mosi_s1 <= 1'b0;
      mosi_s2 <= 1'b0;
      ol_s1   <= '0;
      ol_s2   <= '0;
    end else if (clk_en) begin
      sclk_s1 <= spi_sclk;
      sclk_s2 <= sclk_s1;
      sclk_d  <= sclk_s2;
      cs_s1   <= chip_select_low_active;
      cs_s2   <= cs_s1;
      cs_d    <= cs_s2;
      mosi_s1 <= spi_mosi;
      mosi_s2 <= mosi_s1;
      ol_s1   <= ol_compare;
      ol_s2   <= ol_s1;
    end
  end

  assign sclk_rise = sclk_s2 & ~sclk_d;
  assign sclk_fall = ~sclk_s2 & sclk_d;
  assign cs_fall   = ~cs_s2 & cs_d;
  assign cs_rise   = cs_s2 & ~cs_d;

  always_comb begin
    next_spi_state = spi_state;
    case (spi_state)
      dfsb_pkg::DFSB_SPI_IDLE: begin
        if (cs_fall) begin
          next_spi_state = dfsb_pkg::DFSB_SPI_FRAME;
        end
      end
      dfsb_pkg::DFSB_SPI_FRAME: begin
        if (cs_rise) begin
          next_spi_state = dfsb_pkg::DFSB_SPI_IDLE;
        end
      end
      default: begin
        next_spi_state = dfsb_pkg::DFSB_SPI_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      spi_state <= dfsb_pkg::DFSB_SPI_IDLE;
    end else if (clk_en) begin
      spi_state <= next_spi_state;
    end
  end

  // bit counter saturates so an overlong frame cannot wrap to a legal one
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      bit_count <= '0;
      rx_shift  <= '0;
    end else if (clk_en) begin
      if (cs_fall) begin
        bit_count <= '0;
      end else if (spi_state == dfsb_pkg::DFSB_SPI_FRAME && sclk_rise) begin
        rx_shift <= {rx_shift[14:0], mosi_s2};
        if (bit_count != dfsb_pkg::COUNT_SAT) begin
          bit_count <= bit_count + 1'b1;
        end
      end
    end
  end

  // answer to the address sent in the last well-formed frame
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_shift <= '0;
    end else if (clk_en) begin
      if (cs_fall) begin
        tx_shift <= {3'h0, resp_addr, read_value};
      end else if (spi_state == dfsb_pkg::DFSB_SPI_FRAME && sclk_fall) begin
        tx_shift <= {tx_shift[14:0], 1'b0};
      end
    end
  end

  assign spi_miso    = tx_shift[15];
  assign spi_miso_oe = (spi_state == dfsb_pkg::DFSB_SPI_FRAME);

  assign frame_ok  = cs_rise && (spi_state == dfsb_pkg::DFSB_SPI_FRAME)
                     && (bit_count == dfsb_pkg::FRAME_BITS);
  assign frame_bad = cs_rise && (spi_state == dfsb_pkg::DFSB_SPI_FRAME)
                     && (bit_count != dfsb_pkg::FRAME_BITS);
  assign rx_addr   = rx_shift[dfsb_pkg::FRM_ADDR_HI:dfsb_pkg::FRM_ADDR_LO];
  assign rx_write  = rx_shift[dfsb_pkg::FRM_WR_BIT];

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      resp_addr <= '0;
    end else if (clk_en && frame_ok) begin
      resp_addr <= rx_addr;
    end
  end

  // pull-down command register, all sources on from power-up
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pulldown_cmd <= dfsb_pkg::PULLDOWN_RESET;
    end else if (clk_en && frame_ok && rx_write
                 && rx_addr == dfsb_pkg::ADDR_PULLDOWN) begin
      pulldown_cmd <= rx_shift[dfsb_pkg::FRM_DATA_HI:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pulldown_enable <= dfsb_pkg::PULLDOWN_RESET;
    end else if (clk_en) begin
      pulldown_enable <= sleep_mode ? '0 : pulldown_cmd;
    end
  end

  // malformed frame is flagged; reading the supply register clears it
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      spi_frame_error <= 1'b0;
    end else if (clk_en) begin
      if (frame_bad) begin
        spi_frame_error <= 1'b1;
      end else if (frame_ok && resp_addr == dfsb_pkg::ADDR_SUPPLY) begin
        spi_frame_error <= 1'b0;
      end
    end
  end

  assign ol_link.restart  = cs_rise;
  assign ol_link.drive_on = drive_on;
  assign ol_link.pd_en    = pulldown_enable;
  assign ol_link.ol_raw   = ol_s2;

  dfsb_ol_filter #(
    .N            (N),
    .DELAY_CYCLES (OL_FILTER_CYCLES)
  ) u_ol_filter (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .clk_en  (clk_en),
    .ol      (ol_link)
  );

  // faults stay until a well-formed frame answering their channel ends; a new one wins
  for (genvar ch = 0; ch < N; ch++) begin : g_ch
    logic [3:0] fault_bits;

    assign ch_clear[ch] = frame_ok && (resp_addr == dfsb_pkg::CH_ADDR[ch]);

    always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
        ol_latch[ch] <= 1'b0;
        oc_latch[ch] <= 1'b0;
        ot_latch[ch] <= 1'b0;
        sg_latch[ch] <= 1'b0;
      end else if (clk_en) begin
        ol_latch[ch] <= ol_link.ol_detect[ch]
                        | (ol_latch[ch] & ~ch_clear[ch]);
        oc_latch[ch] <= overcurrent_flag[ch]
                        | (oc_latch[ch] & ~ch_clear[ch]);
        ot_latch[ch] <= overtemperature_flag[ch]
                        | (ot_latch[ch] & ~ch_clear[ch]);
        sg_latch[ch] <= short_to_ground_flag[ch]
                        | (sg_latch[ch] & ~ch_clear[ch]);
      end
    end

    // the driver is never shut off here, so it runs on once the load is back
    assign fault_bits = {ol_latch[ch] & pulldown_enable[ch],
                         oc_latch[ch], ot_latch[ch], sg_latch[ch]}
                        & dfsb_pkg::CH_FAULT_MASK[ch];
    assign ch_summary[ch] = |fault_bits;
    assign fault_reg[ch] = {ch_summary[ch], 3'h0, fault_bits};
  end

  assign onoff_reg = {drive_on[0], drive_on[1], drive_on[2], drive_on[3],
                      drive_on[5], drive_on[7], drive_on[8], drive_on[6]};

  assign any_fault = (|ch_summary)
                     | (|(sensor_faults & dfsb_pkg::SENSOR_FAULT_MASK))
                     | (|(supply_status & dfsb_pkg::SUPPLY_FAULT_MASK))
                     | spi_frame_error;

  always_comb begin
    supply_reg = supply_status;
    supply_reg[dfsb_pkg::BIT_SPI_ERR] = supply_status[dfsb_pkg::BIT_SPI_ERR]
                                        | spi_frame_error;
    supply_reg[dfsb_pkg::BIT_SUMMARY] = any_fault;
  end

  always_comb begin
    case (resp_addr)
      dfsb_pkg::ADDR_PULLDOWN: read_value = pulldown_enable;
      dfsb_pkg::ADDR_WDOG:     read_value = {1'b0, watchdog_state};
      dfsb_pkg::ADDR_SENSOR:
        read_value = {1'b0, sensor_faults & dfsb_pkg::SENSOR_READ_MASK};
      dfsb_pkg::ADDR_SUPPLY:   read_value = {1'b0, supply_reg};
      dfsb_pkg::ADDR_ONOFF:    read_value = {1'b0, onoff_reg};
      dfsb_pkg::ADDR_MODEL:    read_value = {1'b0, MODEL_CODE, REVISION};
      default:                 read_value = {1'b0, dfsb_pkg::REG_RESET};
    endcase
    for (int i = 0; i < N; i++) begin
      if (resp_addr == dfsb_pkg::CH_ADDR[i]) begin
        read_value = {1'b0, fault_reg[i]};
      end
    end
  end

endmodule

// ### core/dfsb_ol_filter.sv
// open-load fault delay timer and per-output qualification
// assumes ol_raw already synchronised to sys_clk
`timescale 1ns/10ps
module dfsb_ol_filter #(
  parameter int unsigned N            = 9,
  parameter int unsigned DELAY_CYCLES = dfsb_pkg::OL_FILTER_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  dfsb_ol_if.filt  ol
);
  localparam int unsigned CW = $clog2(DELAY_CYCLES + 1);
  localparam logic [CW-1:0] DELAY_END = CW'(DELAY_CYCLES);

  logic [CW-1:0] delay_count;
  logic          timer_done;

  // counts from power-up too, so the first frame is not needed to arm it
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      delay_count <= '0;
    end else if (clk_en) begin
      if (ol.restart) begin
        delay_count <= '0;
      end else if (!timer_done) begin
        delay_count <= delay_count + 1'b1;
      end
    end
  end

  assign timer_done = (delay_count == DELAY_END);

  for (genvar ch = 0; ch < N; ch++) begin : g_ch
    always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
        ol.ol_detect[ch] <= 1'b0;
      end else if (clk_en) begin
        // no detection while driven on or without the pull-down current
        ol.ol_detect[ch] <= timer_done
                            & ~ol.drive_on[ch]
                            & ol.pd_en[ch]
                            & ol.ol_raw[ch];
      end
    end
  end
endmodule

// ### core/dfsb_ol_if.sv
// open-load signals passed between the register bank and its filter
// assumes both ends run on sys_clk
`timescale 1ns/10ps
interface dfsb_ol_if #(
  parameter int unsigned N = 9
);
  logic         restart;
  logic [N-1:0] drive_on;
  logic [N-1:0] pd_en;
  logic [N-1:0] ol_raw;
  logic [N-1:0] ol_detect;

  modport bank (output restart, output drive_on, output pd_en,
                output ol_raw, input ol_detect);
  modport filt (input restart, input drive_on, input pd_en,
                input ol_raw, output ol_detect);
endinterface

// ### core/dfsb_pkg.sv
// fault-status register bank: shared constants, register map, field layout
// assumes a 50 MHz system clock and a 16-bit serial frame, most significant
// bit first
//
// What this block does
// - first injector: bit3 open load, bit2 overcurrent, bit1 temp, bit0 short
// - second injector, relays, lamp same layout; tacho has bit0 reserved
// - spark and heater registers report only bits 3 and 2, plus bit 7
// - open load is detected only while the output's control bit is low
// - every pull-down source is enabled at power-up
// - open-load bit reads 0 while that output's pull-down is off
// - pull-down turns off only in sleep or by serial command
// - open-load fault filter lasts between 100 and 450 microseconds
// - chip-select rising edge restarts the fault delay timer
// - comparator cannot register a fault before the delay timer expires
// - detected open load stays latched for the controller to read later
// - output resumes normal operation by itself once open load is gone
package dfsb_pkg;

  localparam int unsigned NUM_CH     = 9;
  localparam int unsigned DATA_W     = 9;
  localparam int unsigned CH_FIRST_HI = 6;

  // serial frame: write flag, address, two zero bits, data
  localparam logic [4:0] FRAME_BITS   = 5'h10;
  localparam logic [4:0] COUNT_SAT    = 5'h1f;
  localparam int unsigned FRM_WR_BIT  = 15;
  localparam int unsigned FRM_ADDR_HI = 14;
  localparam int unsigned FRM_ADDR_LO = 11;
  localparam int unsigned FRM_DATA_HI = 8;

  // register addresses
  localparam logic [3:0] ADDR_PULLDOWN = 4'h6;
  localparam logic [3:0] ADDR_WDOG     = 4'ha;
  localparam logic [3:0] ADDR_SENSOR   = 4'hb;
  localparam logic [3:0] ADDR_SUPPLY   = 4'hd;
  localparam logic [3:0] ADDR_ONOFF    = 4'he;
  localparam logic [3:0] ADDR_MODEL    = 4'hf;

  // channel order: injector_one_output injector_two_output relay_one_output relay_two_output tacho lamp heater spark1 spark2
  localparam logic [3:0] CH_ADDR [NUM_CH] = '{
    4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h7, 4'h8, 4'h9};
  // implemented fault bits per channel, {open, over-i, over-t, short}
  localparam logic [3:0] CH_FAULT_MASK [NUM_CH] = '{
    4'hf, 4'hf, 4'hf, 4'hf, 4'he, 4'hf, 4'hc, 4'hc, 4'hc};

  // field positions of a driver fault register, plus the supply register's serial-error bit
  localparam int unsigned BIT_SUMMARY = 7;
  localparam int unsigned BIT_OL      = 3;
  localparam int unsigned BIT_OC      = 2;
  localparam int unsigned BIT_OT      = 1;
  localparam int unsigned BIT_SG      = 0;
  localparam int unsigned BIT_SPI_ERR = 3;

  localparam logic [7:0] SENSOR_READ_MASK  = 8'hef;
  localparam logic [7:0] SENSOR_FAULT_MASK = 8'h07;
  localparam logic [7:0] SUPPLY_FAULT_MASK = 8'h0f;
  localparam logic [7:0] REG_RESET         = 8'h00;
  localparam logic [8:0] PULLDOWN_RESET    = 9'h1ff;

  // open-load filter: the least figure is used, at the lower end of the window
  localparam int unsigned SYS_CLK_MHZ      = 50;
  localparam int unsigned OL_FILTER_MIN_US = 100;
  localparam int unsigned OL_FILTER_MAX_US = 450;
  localparam int unsigned OL_FILTER_CYCLES = OL_FILTER_MIN_US * SYS_CLK_MHZ;
  localparam int unsigned OL_FILTER_MAX_CYCLES =
    OL_FILTER_MAX_US * SYS_CLK_MHZ;

  typedef enum logic [1:0] {
    DFSB_SPI_IDLE  = 2'b01,
    DFSB_SPI_FRAME = 2'b10
  } dfsb_spi_state_t;

endpackage
